// ==== rtl/led_dim_pkg.sv ====
// constants, types and state layout of the led dimming controller
package led_dim_pkg;
    localparam int CLOCK_HZ = 20_000_000;
    localparam int PROBE_TIME_US = 4000;
    localparam int PROBE_CYCLES = PROBE_TIME_US * (CLOCK_HZ / 1_000_000);
    localparam int NUM_CH = 6;
    localparam logic [9:0] UNUSED_MV = 10'h258;
    localparam logic [9:0] FB_TARGET_MV = 10'h15E;
    localparam logic [7:0] ADDR_DIM_PERIOD = 8'h00;
    localparam logic [7:0] ADDR_SW_PERIOD = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_FEEDBACK = 8'h0C;
    localparam logic [19:0] DIM_PERIOD_RST = 20'h0_03E8;
    localparam logic [15:0] SW_PERIOD_RST = 16'h0028;
    localparam int ST_USED_LSB = 8;
    localparam int ST_DIRECT = 16;
    localparam int ST_SEEN = 17;
    localparam int ST_PROBING = 18;
    localparam int ST_ENABLED = 19;
    localparam int ST_MINREG = 20;
    localparam logic [19:0] CNT_MAX = 20'hF_FFFF;
    localparam logic [3:0] DIV_STEPS = 4'h8;

    typedef logic [NUM_CH-1:0][9:0] sink_mv_t;

    typedef struct packed {
        logic en_q;
        logic probing;
        logic [19:0] probe_cnt;
        logic [5:0] used;
        logic direct;
        logic seen;
        logic pwm_q;
        logic [19:0] hi_cnt;
        logic [19:0] per_cnt;
        logic [20:0] rem;
        logic [19:0] divisor;
        logic [3:0] div_step;
        logic [7:0] quo;
        logic [7:0] duty;
        logic [19:0] dim_period;
        logic [15:0] sw_period;
        logic [22:0] phase;
        logic [15:0] sw_cnt;
        logic [5:0] sink_en;
        logic probe_en;
        logic min_reg;
        logic boost_gate;
        logic boost_raise;
        logic [9:0] lowest;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } dim_state_t;
endpackage : led_dim_pkg

// ==== rtl/led_dimming_phase_shift_ctrl.sv ====
// led dimming controller with phase-shift generator and apb registers
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/10ps
module led_dimming_phase_shift_ctrl #(
    parameter int PROBE_LEN = led_dim_pkg::PROBE_CYCLES
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic enable,
    input wire logic brightness_input_pin,
    input wire logic brightness_input_driven,
    input wire logic dim_freq_mode_pin,
    input wire led_dim_pkg::sink_mv_t sink_feedback_pin,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    output logic [5:0] sink_en,
    output logic probe_en,
    output logic min_reg,
    output logic boost_gate,
    output logic boost_raise,
    output logic [9:0] lowest_mv
);
    led_dim_pkg::dim_state_t state;
    led_dim_pkg::dim_state_t next_state;
    logic [2:0] used_count;
    logic [22:0] span;
    logic [5:0] ps_on;

    function automatic logic [2:0] count_bits(input logic [5:0] v);
        logic [2:0] c;
        c = 3'h0;
        for (int k = 0; k < 6; k++) begin
            c = c + {2'h0, v[k]};
        end
        return c;
    endfunction : count_bits

    assign used_count = count_bits(state.used);
    assign span = 23'(used_count) * 23'(state.dim_period);

    generate
        for (genvar i = 0; i < 6; i++) begin : g_chan
            logic [2:0] rank;
            logic [22:0] offset;
            logic [22:0] diff;
            logic [30:0] thresh;
            assign rank = count_bits(state.used & 6'((1 << i) - 1));
            assign offset = 23'(rank) * 23'(state.dim_period);
            assign diff = (state.phase >= offset) ? state.phase - offset
                : 23'(state.phase + span - offset);
            assign thresh = (31'(state.duty) * 31'(span)) >> 8;
            assign ps_on[i] = state.used[i] && (31'(diff) < thresh);
        end
    endgenerate

    always_comb begin
        logic rise;
        logic [20:0] r2;
        logic [7:0] raw;
        logic take;
        logic [22:0] ph;
        logic [9:0] low;
        logic any;
        logic [7:0] a;
        logic hit;
        next_state = state;
        rise = 1'b0;
        r2 = 21'h0;
        raw = 8'h0;
        take = 1'b0;
        ph = 23'h0;
        low = 10'h3FF;
        any = 1'b0;
        a = paddr[7:0];
        hit = 1'b0;

        // apb slave, one wait state
        hit = paddr[31:8] == 24'h0 && (a == led_dim_pkg::ADDR_DIM_PERIOD
            || a == led_dim_pkg::ADDR_SW_PERIOD
            || a == led_dim_pkg::ADDR_STATUS
            || a == led_dim_pkg::ADDR_FEEDBACK);
        next_state.pready = psel && penable && !state.pready;
        next_state.pslverr = 1'b0;
        // writes land at the edge that samples ready high
        if (psel && penable && state.pready && pwrite && hit) begin
            if (a == led_dim_pkg::ADDR_DIM_PERIOD && pwdata[19:0] != 20'h0)
            begin
                next_state.dim_period = pwdata[19:0];
                next_state.phase = 23'h0;
            end
            if (a == led_dim_pkg::ADDR_SW_PERIOD && pwdata[15:1] != 15'h0)
            begin
                next_state.sw_period = pwdata[15:0];
            end
        end
        if (psel && penable && !state.pready) begin
            next_state.pslverr = !hit;
            next_state.prdata = 32'h0000_0000;
            if (!pwrite && hit) begin
                unique case (a)
                    led_dim_pkg::ADDR_DIM_PERIOD:
                        next_state.prdata = {12'h000, state.dim_period};
                    led_dim_pkg::ADDR_SW_PERIOD:
                        next_state.prdata = {16'h0000, state.sw_period};
                    led_dim_pkg::ADDR_STATUS: begin
                        next_state.prdata[7:0] = state.duty;
                        next_state.prdata[led_dim_pkg::ST_USED_LSB +: 6] =
                            state.used;
                        next_state.prdata[led_dim_pkg::ST_DIRECT] =
                            state.direct;
                        next_state.prdata[led_dim_pkg::ST_SEEN] = state.seen;
                        next_state.prdata[led_dim_pkg::ST_PROBING] =
                            state.probing;
                        next_state.prdata[led_dim_pkg::ST_ENABLED] =
                            state.en_q;
                        next_state.prdata[led_dim_pkg::ST_MINREG] =
                            state.min_reg;
                    end
                    led_dim_pkg::ADDR_FEEDBACK:
                        next_state.prdata = {21'h0, state.boost_raise,
                            state.lowest};
                    default: next_state.prdata = 32'h0000_0000;
                endcase
            end
        end

        next_state.en_q = enable;
        next_state.pwm_q = brightness_input_pin;
        rise = brightness_input_pin && !state.pwm_q;

        if (!enable) begin
            next_state.probing = 1'b0;
            next_state.probe_cnt = 20'h0;
            next_state.used = 6'h00;
            next_state.seen = 1'b0;
            next_state.hi_cnt = 20'h0;
            next_state.per_cnt = 20'h0;
            next_state.div_step = 4'h0;
            next_state.duty = 8'h00;
            next_state.phase = 23'h0;
            next_state.sw_cnt = 16'h0;
            next_state.sink_en = 6'h00;
            next_state.probe_en = 1'b0;
            next_state.min_reg = 1'b0;
            next_state.boost_gate = 1'b0;
            next_state.boost_raise = 1'b0;
        end else if (!state.en_q) begin
            next_state.probing = 1'b1;
            next_state.probe_en = 1'b1;
            next_state.probe_cnt = 20'h0;
            next_state.direct = dim_freq_mode_pin;
        end else if (state.probing) begin
            next_state.probe_cnt = state.probe_cnt + 20'h1;
            if (state.probe_cnt == 20'(PROBE_LEN - 1)) begin
                for (int k = 0; k < 6; k++) begin
                    next_state.used[k] =
                        sink_feedback_pin[k] >= led_dim_pkg::UNUSED_MV;
                end
                next_state.probing = 1'b0;
                next_state.probe_en = 1'b0;
            end
        end else begin
            if (brightness_input_driven) begin
                next_state.seen = 1'b1;
            end
            next_state.min_reg = !(state.seen || brightness_input_driven);

            if (!state.direct) begin
                if (rise) begin
                    next_state.hi_cnt = 20'h1;
                    next_state.per_cnt = 20'h1;
                    if (state.hi_cnt >= state.per_cnt) begin
                        raw = 8'hFF;
                        take = 1'b1;
                    end else begin
                        next_state.rem = {1'b0, state.hi_cnt};
                        next_state.divisor = state.per_cnt;
                        next_state.div_step = led_dim_pkg::DIV_STEPS;
                        next_state.quo = 8'h00;
                    end
                end else begin
                    if (state.per_cnt != led_dim_pkg::CNT_MAX) begin
                        next_state.per_cnt = state.per_cnt + 20'h1;
                        next_state.hi_cnt = state.hi_cnt
                            + {19'h0, brightness_input_pin};
                    end else begin
                        raw = state.pwm_q ? 8'hFF : 8'h00;
                        take = 1'b1;
                    end
                end
                if (state.div_step != 4'h0) begin
                    r2 = {state.rem[19:0], 1'b0};
                    next_state.div_step = state.div_step - 4'h1;
                    if (r2 >= {1'b0, state.divisor}) begin
                        next_state.rem = r2 - {1'b0, state.divisor};
                        next_state.quo = {state.quo[6:0], 1'b1};
                    end else begin
                        next_state.rem = r2;
                        next_state.quo = {state.quo[6:0], 1'b0};
                    end
                    if (state.div_step == 4'h1) begin
                        raw = next_state.quo;
                        take = 1'b1;
                    end
                end
                // rise one lsb, fall needs two
                if (take && (raw > state.duty
                    || 9'(raw) + 9'h2 <= 9'(state.duty))) begin
                    next_state.duty = raw;
                end

                ph = state.phase + 23'(used_count);
                next_state.phase = (ph >= span) ? ph - span : ph;
            end

            if (!state.seen) begin
                next_state.sink_en = 6'h00;
            end else if (state.direct) begin
                next_state.sink_en = state.used
                    & {6{brightness_input_pin}};
            end else begin
                next_state.sink_en = ps_on;
            end

            if (state.sw_cnt + 16'h1 >= state.sw_period) begin
                next_state.sw_cnt = 16'h0;
            end else begin
                next_state.sw_cnt = state.sw_cnt + 16'h1;
            end
            next_state.boost_gate = (state.used != 6'h00)
                && (state.sw_cnt < (state.sw_period >> 1));

            for (int k = 0; k < 6; k++) begin
                if (state.used[k] && sink_feedback_pin[k] < low) begin
                    low = sink_feedback_pin[k];
                    any = 1'b1;
                end
            end
            next_state.lowest = any ? low : 10'h000;
            next_state.boost_raise = any
                && low < led_dim_pkg::FB_TARGET_MV;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= '0;
            state.dim_period <= led_dim_pkg::DIM_PERIOD_RST;
            state.sw_period <= led_dim_pkg::SW_PERIOD_RST;
        end else begin
            state <= next_state;
        end
    end

    assign pready = state.pready;
    assign pslverr = state.pslverr;
    assign prdata = state.prdata;
    assign sink_en = state.sink_en;
    assign probe_en = state.probe_en;
    assign min_reg = state.min_reg;
    assign boost_gate = state.boost_gate;
    assign boost_raise = state.boost_raise;
    assign lowest_mv = state.lowest;
endmodule : led_dimming_phase_shift_ctrl

// ==== sim/pwm_host_model.sv ====
// host brightness pwm source model
`timescale 1ns/10ps
module pwm_host_model (
    input wire logic clock,
    input wire logic [15:0] period,
    input wire logic [15:0] high,
    input wire logic drive,
    output logic pin,
    output logic driven
);
    logic [15:0] cnt = 16'h0000;
    initial pin = 1'b0;
    initial driven = 1'b0;
    always @(posedge clock) begin
        cnt <= (cnt + 16'h0001 >= period) ? 16'h0000 : cnt + 16'h0001;
        driven <= drive;
        pin <= drive ? (cnt < high) : ~pin;
    end
endmodule : pwm_host_model

// ==== sim/led_dim_chk.sv ====
// port assertions for the led dimming controller
`timescale 1ns/10ps
module led_dim_chk #(
    parameter int PROBE_LEN = 20
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic enable,
    input wire logic brightness_input_pin,
    input wire logic dim_freq_mode_pin,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [5:0] sink_en,
    input wire logic probe_en,
    input wire logic min_reg,
    input wire logic boost_gate,
    input wire logic boost_raise,
    input wire logic [9:0] lowest_mv
);
    logic [19:0] probe_cnt;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            probe_cnt <= 20'h0_0000;
        end else begin
            probe_cnt <= probe_en ? probe_cnt + 20'h0_0001 : 20'h0_0000;
        end
    end
    sequence apb_take;
        psel && penable && !pready;
    endsequence
    sequence one_pulse;
        pready ##1 !pready;
    endsequence
    apb_answer_a: assert property (apb_take |=> one_pulse)
        else $error("apb answer is not a one-cycle pulse");
    apb_error_a: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    direct_follow_a: assert property (
        enable && dim_freq_mode_pin && !brightness_input_pin
        |=> sink_en == 6'h00) else $error("direct sink on with pin low");
    shutdown_off_a: assert property (
        !enable |=> sink_en == 6'h00 && !probe_en && !boost_gate && !min_reg)
        else $error("activity while enable low");
    probe_len_a: assert property (
        $fell(probe_en) && enable && probe_cnt != 20'h0_0000
        |-> probe_cnt == PROBE_LEN) else $error("probe length wrong");
    probe_dark_a: assert property (probe_en |-> sink_en == 6'h00)
        else $error("sink on during probe");
    float_dark_a: assert property (min_reg |-> sink_en == 6'h00)
        else $error("sink on while input floats");
    raise_level_a: assert property (
        enable && lowest_mv != 10'h000 && $stable(lowest_mv)
        && $past(lowest_mv) == $past(lowest_mv, 2)
        |-> boost_raise == (lowest_mv < led_dim_pkg::FB_TARGET_MV))
        else $error("boost raise disagrees with lowest sink");
    gate_width_a: assert property (
        disable iff (!arst_n || !enable) $rose(boost_gate) |-> boost_gate[*5])
        else $error("converter gate pulse too short");
endmodule : led_dim_chk
bind led_dimming_phase_shift_ctrl led_dim_chk #(.PROBE_LEN(PROBE_LEN)) chk (
    .clock(clock), .arst_n(arst_n), .enable(enable),
    .brightness_input_pin(brightness_input_pin),
    .dim_freq_mode_pin(dim_freq_mode_pin), .psel(psel), .penable(penable),
    .pready(pready), .pslverr(pslverr), .sink_en(sink_en),
    .probe_en(probe_en), .min_reg(min_reg), .boost_gate(boost_gate),
    .boost_raise(boost_raise), .lowest_mv(lowest_mv)
);

// ==== sim/testbench.sv ====
// self-checking bench for the led dimming controller
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin \
    failures++; $display("BAD %s exp %0h got %0h", nm, exp, got); end end
module testbench;
    typedef struct {int per; int hi; logic [7:0] duty;} row_t;
    logic clock = 1'b0, arst_n = 1'b0, enable = 1'b0, mode = 1'b0;
    logic drive = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000, rd, prdata;
    logic pready, pslverr, er, probe_en, min_reg, boost_gate, boost_raise;
    logic pin, driven, p;
    logic [5:0] sink_en;
    logic [9:0] lowest_mv;
    logic [15:0] per = 16'h0100, hi = 16'h0080;
    led_dim_pkg::sink_mv_t mv = {10'h000, 10'h000, 10'h257, 10'h2BC,
        10'h2BC, 10'h258};
    wire logic [6:0] obs = {boost_gate, sink_en};
    int failures = 0, n_tests = 0, t, n;
    row_t rows[6] = '{'{256, 128, 8'h80}, '{256, 130, 8'h82},
        '{256, 129, 8'h82}, '{256, 128, 8'h80}, '{256, 1, 8'h01},
        '{100, 50, 8'h80}};
    always #25 clock = ~clock;
    led_dimming_phase_shift_ctrl #(.PROBE_LEN(20)) dut (.clock(clock),
        .arst_n(arst_n), .enable(enable), .brightness_input_pin(pin),
        .brightness_input_driven(driven), .dim_freq_mode_pin(mode),
        .sink_feedback_pin(mv), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .sink_en(sink_en),
        .probe_en(probe_en), .min_reg(min_reg), .boost_gate(boost_gate),
        .boost_raise(boost_raise), .lowest_mv(lowest_mv));
    pwm_host_model host (.clock(clock), .period(per), .high(hi),
        .drive(drive), .pin(pin), .driven(driven));
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h00_0000, a};
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic st;
        apb(1'b0, led_dim_pkg::ADDR_STATUS, 32'h0000_0000);
    endtask : st
    task automatic rise(input int b);
        int k;
        k = 0;
        do begin
            p = obs[b];
            @(posedge clock);
            #1;
            k++;
        end while (!(p === 1'b0 && obs[b] === 1'b1) && k < 500);
    endtask : rise
    task automatic high_in(input int b, input int len);
        n = 0;
        repeat (len) begin
            @(posedge clock);
            #1;
            n += int'(obs[b]);
        end
    endtask : high_in
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    initial begin
        #1_000_000;
        failures++;
        close_out();
    end
    initial begin
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        apb(1'b0, led_dim_pkg::ADDR_DIM_PERIOD, 32'h0000_0000);
        `CHK("dim period", led_dim_pkg::DIM_PERIOD_RST, rd[19:0])
        apb(1'b0, led_dim_pkg::ADDR_SW_PERIOD, 32'h0000_0000);
        `CHK("sw period", led_dim_pkg::SW_PERIOD_RST, rd[15:0])
        apb(1'b0, 8'h10, 32'h0000_0000);
        `CHK("unmapped", 1'b1, er)
        $display("done registers");
        enable <= 1'b1;
        repeat (30) @(posedge clock);
        st();
        `CHK("used mask", 6'h07, rd[13:8])
        `CHK("phase mode", 1'b0, rd[16])
        `CHK("min reg", 1'b1, min_reg)
        `CHK("float sinks", 6'h00, sink_en)
        mv[3] <= 10'h2BC;
        mv[1] <= 10'h12C;
        repeat (4) @(posedge clock);
        `CHK("lowest", 10'h12C, lowest_mv)
        `CHK("raise", 1'b1, boost_raise)
        mv[1] <= 10'h2BC;
        repeat (4) @(posedge clock);
        `CHK("lowest", 10'h258, lowest_mv)
        $display("done start-up");
        drive <= 1'b1;
        foreach (rows[i]) begin
            per <= 16'(rows[i].per);
            hi <= 16'(rows[i].hi);
            repeat (3 * rows[i].per + 20) @(posedge clock);
            st();
            `CHK("duty", rows[i].duty, rd[7:0])
        end
        `CHK("min reg off", 1'b0, min_reg)
        $display("done duty rows");
        apb(1'b1, led_dim_pkg::ADDR_DIM_PERIOD, 32'h0000_003C);
        rise(0);
        rise(0);
        t = int'($time);
        rise(1);
        `CHK("stagger", 20, (int'($time) - t) / 50)
        high_in(0, 60);
        `CHK("sink high", 30, n)
        `CHK("unused off", 3'h0, sink_en[5:3])
        apb(1'b1, led_dim_pkg::ADDR_SW_PERIOD, 32'h0000_000A);
        rise(6);
        t = int'($time);
        rise(6);
        `CHK("gate period", 10, (int'($time) - t) / 50)
        high_in(6, 10);
        `CHK("gate high", 5, n)
        $display("done phase shift");
        @(posedge clock);
        enable <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        `CHK("shutdown", 7'h00, obs)
        @(posedge clock);
        mode <= 1'b1;
        enable <= 1'b1;
        repeat (2) @(posedge clock);
        `CHK("probe on", 1'b1, probe_en)
        repeat (38) @(posedge clock);
        repeat (40) begin
            @(posedge clock);
            p = pin;
            #1;
            `CHK("direct", p ? 6'h0F : 6'h00, sink_en)
        end
        st();
        `CHK("direct mode", 1'b1, rd[16])
        `CHK("restart mask", 6'h0F, rd[13:8])
        `CHK("no decode", 8'h00, rd[7:0])
        $display("done direct mode");
        close_out();
    end
endmodule : testbench
